/* File: common/adc_seq_pkg.sv */
package adc_seq_pkg;
	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [4:0] IDX_RESULT_LOW  = 5'h04;
	localparam logic [4:0] IDX_RESULT_HIGH = 5'h05;
	localparam logic [4:0] IDX_CTRL_STATUS = 5'h06;
	localparam logic [4:0] IDX_CHAN_SEL    = 5'h07;
	localparam int         ADDR_W          = 7;
	localparam logic [6:0] ADDR_RESULT_LOW  = {IDX_RESULT_LOW, 2'b00};
	localparam logic [6:0] ADDR_RESULT_HIGH = {IDX_RESULT_HIGH, 2'b00};
	localparam logic [6:0] ADDR_CTRL_STATUS = {IDX_CTRL_STATUS, 2'b00};
	localparam logic [6:0] ADDR_CHAN_SEL    = {IDX_CHAN_SEL, 2'b00};

	// ------------------------------------------------------------
	// Control/status field positions and reset values
	// ------------------------------------------------------------
	localparam int         BIT_ON       = 7;
	localparam int         BIT_GO       = 6;
	localparam int         BIT_FREE     = 5;
	localparam int         BIT_FLAG     = 4;
	localparam int         BIT_IRQ_EN   = 3;
	localparam int         DIV_MSB      = 2;
	localparam int         CHAN_MSB     = 2;
	localparam logic [7:0] CSR_RESET    = 8'h00;
	localparam logic [2:0] CHAN_RESET   = 3'h0;

	// ------------------------------------------------------------
	// Conversion lengths in converter clock ticks
	// ------------------------------------------------------------
	localparam logic [4:0] LEN_FIRST  = 5'h19;  // 25 with the dummy pass
	localparam logic [4:0] LEN_SINGLE = 5'h0E;  // 14
	localparam logic [4:0] LEN_FREE   = 5'h0D;  // 13
	localparam int         RES_W      = 10;

	// Signals towards the analog converter core
	typedef struct packed {
		logic       on;
		logic       busy;
		logic       dummy;
		logic       tick;
		logic [2:0] chan;
	} core_ctl_t;
endpackage

/* File: src/adc_conversion_sequencer.sv */
// Notes on behaviour
// - single or free-running mode by select bit
// - enable bit powers converter on and off
// - clearing enable aborts running conversion
// - first conversion after enable takes 25 ticks
// - dummy also when start and enable together
// - start bit reads one while converting
// - start bit holds through dummy and real
// - writing zero to start does nothing
// - channel change waits for conversion end
// - reading low byte locks result registers
// - completion while locked discards result
// - reading high byte releases the lock
// - done flag set even when result discarded
// - free running: 13 ticks, auto restart
// - single conversion takes 14 ticks
// - idle entry starts a conversion
// - idle conversion completion raises interrupt
// - channel field picks input 0 to 7
// - upper channel register bits read zero
// - done flag set, cleared by vector or one
// - clearing free-run bit ends free running
// - prescaler 2,2,4,...,128 from code
// - interrupt needs enable and global enable
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   clk_en,
	input  wire logic [ADDR_W-1:0]      avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	input  wire logic [RES_W-1:0]       core_result,
	output core_ctl_t                   core_ctl,
	input  wire logic                   cpu_idle,
	input  wire logic                   global_irq_en,
	input  wire logic                   irq_vector_ack,
	output logic                        conv_irq
);

	// ------------------------------------------------------------
	// Bus slave: one wait cycle on every access
	// ------------------------------------------------------------
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        acc_first;
	logic        wr_done;
	logic        rd_first;

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign acc_first       = (avs_read | avs_write) & ~ack_r;
	assign wr_done         = avs_write & ack_r;
	assign rd_first        = avs_read & ~ack_r;
	assign avs_readdata    = rdata_r;

	// ------------------------------------------------------------
	// Register and sequencer state
	// ------------------------------------------------------------
	logic                 on_r, on_nxt;
	logic                 busy_r, busy_nxt;
	logic                 free_r, free_nxt;
	logic                 flag_r, flag_nxt;
	logic                 ie_r, ie_nxt;
	logic [DIV_MSB:0]     div_r, div_nxt;
	logic [CHAN_MSB:0]    chan_r, chan_nxt;
	logic [CHAN_MSB:0]    act_chan_r, act_chan_nxt;
	logic                 dummy_pend_r, dummy_pend_nxt;
	logic                 dummy_run_r, dummy_run_nxt;
	logic                 lock_r, lock_nxt;
	logic [RES_W-1:0]     result_r, result_nxt;
	logic [4:0]           cnt_r, cnt_nxt;
	logic [6:0]           pre_r, pre_nxt;
	logic                 tick_r, tick_nxt;
	logic                 idle_d_r;

	// Decoded bus events
	logic wr_csr, wr_chan, rd_low, rd_high;
	logic start_sw, start_idle, start_any, done, abort;
	logic [6:0] pre_top;

	assign wr_csr  = wr_done && (avs_address == ADDR_CTRL_STATUS);
	assign wr_chan = wr_done && (avs_address == ADDR_CHAN_SEL);
	assign rd_low  = rd_first && (avs_address == ADDR_RESULT_LOW);
	assign rd_high = rd_first && (avs_address == ADDR_RESULT_HIGH);

	// divisor mask, codes 0 and 1 both halve
	assign pre_top = (div_r == 3'h0) ? 7'h01 : 7'((8'h01 << div_r) - 8'h01);

	// disabling drops any conversion at once
	assign abort = wr_csr && !avs_writedata[BIT_ON];
	// only a written one starts; a zero is ignored
	assign start_sw = wr_csr && avs_writedata[BIT_ON] && avs_writedata[BIT_GO] && !busy_r;
	// idle entry while set up starts a conversion
	assign start_idle = cpu_idle && !idle_d_r && on_r && !busy_r && !free_r && ie_r;
	assign start_any  = start_sw || (start_idle && !wr_csr);
	assign done       = busy_r && tick_r && (cnt_r == 5'h01) && !abort;

	// ------------------------------------------------------------
	// Next-state logic for the whole sequencer
	// ------------------------------------------------------------
	always_comb begin
		ack_nxt        = acc_first;
		rdata_nxt      = rdata_r;
		on_nxt         = on_r;
		busy_nxt       = busy_r;
		free_nxt       = free_r;
		flag_nxt       = flag_r;
		ie_nxt         = ie_r;
		div_nxt        = div_r;
		chan_nxt       = chan_r;
		act_chan_nxt   = act_chan_r;
		dummy_pend_nxt = dummy_pend_r;
		dummy_run_nxt  = dummy_run_r;
		lock_nxt       = lock_r;
		result_nxt     = result_r;
		cnt_nxt        = cnt_r;
		pre_nxt        = pre_r;
		tick_nxt       = 1'b0;

		// Prescaler runs only while the converter is powered
		if (on_r) begin
			if (pre_r >= pre_top) begin
				pre_nxt  = 7'h00;
				tick_nxt = 1'b1;
			end else begin
				pre_nxt = pre_r + 7'h01;
			end
		end else begin
			pre_nxt = 7'h00;
		end

		// Read data captured at the first edge, with its side effect
		if (rd_first) begin
			if (avs_address == ADDR_RESULT_LOW) begin
				rdata_nxt = {24'h00_0000, result_r[7:0]};
			end else if (avs_address == ADDR_RESULT_HIGH) begin
				rdata_nxt = {30'h0000_0000, result_r[9:8]};
			end else if (avs_address == ADDR_CTRL_STATUS) begin
				// start bit reflects conversion in progress
				rdata_nxt = {24'h00_0000, on_r, busy_r, free_r, flag_r, ie_r, div_r};
			end else if (avs_address == ADDR_CHAN_SEL) begin
				rdata_nxt = {29'h0000_0000, chan_r};
			end else begin
				rdata_nxt = 32'h0000_0000;
			end
		end

		if (rd_low) begin
			lock_nxt = 1'b1;
		end
		// high byte read lifts the block
		if (rd_high) begin
			lock_nxt = 1'b0;
		end

		// Channel register; converter keeps act_chan
		if (wr_chan) begin
			chan_nxt = avs_writedata[CHAN_MSB:0];
		end

		// Flag clear by vector or by writing one
		if (irq_vector_ack || (wr_csr && avs_writedata[BIT_FLAG])) begin
			flag_nxt = 1'b0;
		end

		if (wr_csr) begin
			on_nxt   = avs_writedata[BIT_ON];
			free_nxt = avs_writedata[BIT_FREE];
			ie_nxt   = avs_writedata[BIT_IRQ_EN];
			div_nxt  = avs_writedata[DIV_MSB:0];
		end

		// Conversion counter
		if (busy_r && tick_r) begin
			cnt_nxt = cnt_r - 5'h01;
			// dummy end leaves the start bit set
			if (dummy_run_r && cnt_r == (LEN_FIRST - LEN_SINGLE + 5'h01)) begin
				dummy_run_nxt = 1'b0;
			end
		end

		if (done) begin
			// flag set on completion, wins over clear
			// also when the result is thrown away
			flag_nxt = 1'b1;
			// locked registers keep the older result
			if (!lock_r && !rd_low) begin
				result_nxt = core_result;
			end
			// free-run select picks restart or stop
			// free running restarts with 13 ticks
			if (free_r && !(wr_csr && !avs_writedata[BIT_FREE])) begin
				cnt_nxt      = LEN_FREE;
				act_chan_nxt = chan_nxt;
			end else begin
				// hardware clears start bit on completion
				busy_nxt = 1'b0;
			end
		end

		if (start_any) begin
			busy_nxt     = 1'b1;
			act_chan_nxt = chan_nxt;
			// first start after enable gets the dummy
			// also when enable and start share a write
			if (dummy_pend_r || !on_r) begin
				cnt_nxt        = LEN_FIRST;
				dummy_run_nxt  = 1'b1;
				dummy_pend_nxt = 1'b0;
			end else begin
				cnt_nxt = LEN_SINGLE;
			end
		end

		// abort and re-arm the dummy pass
		if (abort || !on_r && !start_any) begin
			busy_nxt       = 1'b0;
			dummy_run_nxt  = 1'b0;
			dummy_pend_nxt = 1'b1;
		end
		if (abort) begin
			cnt_nxt = 5'h00;
		end
	end

	// ------------------------------------------------------------
	// Registers, frozen while clk_en is low
	// ------------------------------------------------------------
	// all state clear except dummy_pend_r, which arms the dummy pass; converter off at reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_r        <= 1'b0;
			rdata_r      <= 32'h0000_0000;
			on_r         <= CSR_RESET[BIT_ON];
			busy_r       <= CSR_RESET[BIT_GO];
			free_r       <= CSR_RESET[BIT_FREE];
			flag_r       <= CSR_RESET[BIT_FLAG];
			ie_r         <= CSR_RESET[BIT_IRQ_EN];
			div_r        <= CSR_RESET[DIV_MSB:0];
			chan_r       <= CHAN_RESET;
			act_chan_r   <= CHAN_RESET;
			dummy_pend_r <= 1'b1;
			dummy_run_r  <= 1'b0;
			lock_r       <= 1'b0;
			result_r     <= 10'h000;
			cnt_r        <= 5'h00;
			pre_r        <= 7'h00;
			tick_r       <= 1'b0;
			idle_d_r     <= 1'b0;
		end else if (clk_en) begin
			ack_r        <= ack_nxt;
			rdata_r      <= rdata_nxt;
			on_r         <= on_nxt;
			busy_r       <= busy_nxt;
			free_r       <= free_nxt;
			flag_r       <= flag_nxt;
			ie_r         <= ie_nxt;
			div_r        <= div_nxt;
			chan_r       <= chan_nxt;
			act_chan_r   <= act_chan_nxt;
			dummy_pend_r <= dummy_pend_nxt;
			dummy_run_r  <= dummy_run_nxt;
			lock_r       <= lock_nxt;
			result_r     <= result_nxt;
			cnt_r        <= cnt_nxt;
			pre_r        <= pre_nxt;
			tick_r       <= tick_nxt;
			idle_d_r     <= cpu_idle;
		end
	end

	// ------------------------------------------------------------
	// Outputs towards core and CPU
	// ------------------------------------------------------------
	// active channel drives the multiplexer
	assign core_ctl.on    = on_r;
	assign core_ctl.busy  = busy_r;
	assign core_ctl.dummy = dummy_run_r;
	assign core_ctl.tick  = tick_r;
	assign core_ctl.chan  = act_chan_r;
	// gated by local and global enable
	// wakes the CPU after an idle conversion
	assign conv_irq = flag_r && ie_r && global_irq_en;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_off_not_busy: assert property (!on_r |-> !busy_r)
		else $error("busy while converter is off");
	a_abort_clears: assert property (clk_en && abort |=> !busy_r && cnt_r == 5'h00)
		else $error("disable did not abort conversion");
	a_first_long: assert property (clk_en && start_any && (dummy_pend_r || !on_r)
		|=> busy_r && cnt_r == 5'h19 && dummy_run_r)
		else $error("first conversion not 25 ticks");
	a_single_len: assert property (clk_en && start_any && on_r && !dummy_pend_r
		|=> cnt_r == 5'h0E)
		else $error("single conversion not 14 ticks");
	a_free_restart: assert property (clk_en && done && free_r && !wr_csr
		|=> busy_r && cnt_r == 5'h0D)
		else $error("free run did not restart with 13 ticks");
	a_lock_keeps: assert property (clk_en && lock_r && !rd_high |=> $stable(result_r))
		else $error("locked result changed");
	a_flag_on_done: assert property (clk_en && done |=> flag_r)
		else $error("done flag not set on completion");
	a_chan_held: assert property (busy_r && $past(busy_r) && !$past(done) |-> $stable(act_chan_r))
		else $error("channel changed mid conversion");
	a_go_zero: assert property (clk_en && wr_csr && !avs_writedata[BIT_GO] && !busy_r && !start_idle
		|=> !busy_r)
		else $error("zero start write began conversion");
	a_irq_gate: assert property (clk_en && done && ie_r && !wr_csr
		|=> conv_irq == global_irq_en)
		else $error("completion interrupt not gated by enables");

	// Start bit and dummy pass
	a_dummy_go: assert property (clk_en && dummy_run_r && busy_r && !abort |=> busy_r)
		else $error("start bit dropped during dummy pass");
	a_done_clears: assert property (clk_en && done && !free_r |=> !busy_r)
		else $error("start bit not cleared at completion");
	a_free_stops: assert property (clk_en && done && wr_csr && !avs_writedata[BIT_FREE]
		|=> !busy_r)
		else $error("free run kept going after select cleared");
	a_go_reads: assert property (clk_en && rd_first && avs_address == ADDR_CTRL_STATUS
		|=> avs_readdata[BIT_GO] == $past(busy_r))
		else $error("start bit read back wrong");

	// Register reads and lock
	a_low_locks: assert property (clk_en && rd_low |=> lock_r)
		else $error("low byte read did not lock");
	a_high_frees: assert property (clk_en && rd_high |=> !lock_r)
		else $error("high byte read did not unlock");
	a_result_load: assert property (clk_en && done && !lock_r && !rd_low
		|=> result_r == $past(core_result))
		else $error("result not loaded at completion");
	a_reserved_zero: assert property (clk_en && rd_first && avs_address == ADDR_CHAN_SEL
		|=> avs_readdata[31:3] == 29'h0000_0000)
		else $error("reserved channel bits not zero");

	// Flag, interrupt, idle start and channel
	a_flag_clear: assert property (clk_en && irq_vector_ack && !done |=> !flag_r)
		else $error("vector did not clear done flag");
	a_flag_wr_clear: assert property (clk_en && wr_csr && avs_writedata[BIT_FLAG] && !done
		|=> !flag_r)
		else $error("writing one did not clear done flag");
	a_idle_start: assert property (clk_en && start_idle && !wr_csr |=> busy_r)
		else $error("idle entry did not start conversion");
	a_chan_apply: assert property (clk_en && start_any && !wr_chan |=> core_ctl.chan == chan_r)
		else $error("multiplexer not set to selected channel");

	// Prescaler
	a_tick_gap: assert property (clk_en && tick_r |=> !tick_r)
		else $error("converter ticks closer than two clocks");
	a_off_quiet: assert property (clk_en && !on_r |=> !tick_r)
		else $error("converter ticks while off");

endmodule

/* File: tb/conv_core_model.sv */
module conv_core_model
	import adc_seq_pkg::*;
(
	input  wire logic        clk,
	input  wire core_ctl_t   core_ctl,
	output logic [RES_W-1:0] core_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [RES_W-1:0] last_r;
	// Last driven value, so an idle core never repeats stale data
	always_ff @(posedge clk) begin
		last_r <= core_result;
	end
	// channel into result
	// Channel in the top bits shows which input was really sampled
	assign core_result = core_ctl.busy ? {core_ctl.chan, 7'h2A} : ~last_r;
endmodule

/* File: tb/testbench.sv */
module testbench
	import adc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk, rst, clk_en, avs_read, avs_write, avs_waitrequest;
	logic [6:0]       avs_address;
	logic [31:0]      avs_writedata, avs_readdata, v;
	logic [RES_W-1:0] core_result;
	core_ctl_t        core_ctl;
	logic             cpu_idle, global_irq_en, irq_vector_ack, conv_irq;
	int               err_total, n_checks, nt, t0, i;

	adc_conversion_sequencer dut (.clk(clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_result(core_result),
		.core_ctl(core_ctl), .cpu_idle(cpu_idle), .global_irq_en(global_irq_en),
		.irq_vector_ack(irq_vector_ack), .conv_irq(conv_irq));
	conv_core_model partner (.clk(clk), .core_ctl(core_ctl), .core_result(core_result));

	// ----------------------------------------
	// Clock, tick counter and helpers
	// ----------------------------------------
	always #20 clk = ~clk;
	// Counts converter ticks inside conversions only
	always @(posedge clk) begin
		if (core_ctl.busy === 1'b1 && core_ctl.tick === 1'b1) nt <= nt + 1;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Bus cycles start one edge late so a strobe never drops and rises in one step
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= 32'(d);
		avs_write     <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a);
		@(posedge clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [6:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, v, e);
	endtask
	task automatic wait_for(input bit irq, input logic lvl);
		i = 0;
		while (((irq ? conv_irq : core_ctl.busy) !== lvl) && i < 3000) begin
			@(posedge clk);
			i++;
		end
		chk("wait", 32'(irq ? conv_irq : core_ctl.busy), 32'(lvl));
	endtask
	task automatic ack_pulse();
		@(posedge clk);
		irq_vector_ack <= 1'b1;
		@(posedge clk);
		irq_vector_ack <= 1'b0;
		// Let the flag clear settle before anyone looks again
		@(posedge clk);
	endtask
	// Start bit is read back mid-run, then ticks counted to the end
	task automatic conv(input logic [7:0] c, input int n);
		t0 = nt;
		wr(ADDR_CTRL_STATUS, c);
		@(posedge clk);
		chk("dummy", 32'(core_ctl.dummy), 32'(n == 25));
		rd(ADDR_CTRL_STATUS);
		chk("start bit", 32'(v[6]), 32'h1);
		wait_for(0, 1'b0);
		chk("ticks", 32'(nt - t0), 32'(n));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk("ctl", 32'(core_ctl), 32'h0);
		rdc("csr", ADDR_CTRL_STATUS, 32'h0);
		rdc("unmapped", 7'h00, 32'h0);
		wr(ADDR_CHAN_SEL, 8'hFF);
		rdc("chan", ADDR_CHAN_SEL, 32'h7);
	endtask
	task automatic t_first();
		wr(ADDR_CHAN_SEL, 8'h05);
		conv(8'hC0, 25);
		rdc("csr", ADDR_CTRL_STATUS, 32'h90);
		rdc("low", ADDR_RESULT_LOW, 32'hAA);
		rdc("high", ADDR_RESULT_HIGH, 32'h2);
	endtask
	task automatic t_chan();
		t0 = nt;
		wr(ADDR_CTRL_STATUS, 8'hD0);
		wr(ADDR_CHAN_SEL, 8'h03);
		wr(ADDR_CTRL_STATUS, 8'h80);
		@(posedge clk);
		chk("busy", 32'(core_ctl.busy), 32'h1);
		wait_for(0, 1'b0);
		chk("ticks", 32'(nt - t0), 32'd14);
		rdc("old chan", ADDR_RESULT_HIGH, 32'h2);
		conv(8'hC0, 14);
		rdc("new chan", ADDR_RESULT_HIGH, 32'h1);
	endtask
	task automatic t_lock();
		wr(ADDR_CHAN_SEL, 8'h06);
		rdc("low", ADDR_RESULT_LOW, 32'hAA);
		conv(8'hD0, 14);
		rdc("flag", ADDR_CTRL_STATUS, 32'h90);
		rdc("kept", ADDR_RESULT_HIGH, 32'h1);
		conv(8'hD0, 14);
		rdc("low", ADDR_RESULT_LOW, 32'h2A);
		rdc("fresh", ADDR_RESULT_HIGH, 32'h3);
	endtask
	task automatic t_irq();
		chk("irq", 32'(conv_irq), 32'h0);
		wr(ADDR_CTRL_STATUS, 8'h88);
		@(posedge clk);
		chk("irq", 32'(conv_irq), 32'h0);
		global_irq_en <= 1'b1;
		@(posedge clk);
		chk("irq", 32'(conv_irq), 32'h1);
		ack_pulse();
		@(posedge clk);
		chk("irq", 32'(conv_irq), 32'h0);
		rdc("csr", ADDR_CTRL_STATUS, 32'h88);
		conv(8'hC8, 14);
		chk("irq", 32'(conv_irq), 32'h1);
		wr(ADDR_CTRL_STATUS, 8'h98);
		@(posedge clk);
		chk("irq", 32'(conv_irq), 32'h0);
	endtask
	task automatic t_free();
		wr(ADDR_CTRL_STATUS, 8'hE8);
		wait_for(1, 1'b1);
		t0 = nt;
		ack_pulse();
		wait_for(1, 1'b1);
		chk("free ticks", 32'(nt - t0), 32'd13);
		ack_pulse();
		wr(ADDR_CTRL_STATUS, 8'h88);
		wait_for(0, 1'b0);
		repeat (60) @(posedge clk);
		chk("stopped", 32'(core_ctl.busy), 32'h0);
	endtask
	task automatic t_abort();
		wr(ADDR_CTRL_STATUS, 8'hD0);
		repeat (8) @(posedge clk);
		wr(ADDR_CTRL_STATUS, 8'h00);
		@(posedge clk);
		chk("off", 32'({core_ctl.on, core_ctl.busy}), 32'h0);
		rdc("csr", ADDR_CTRL_STATUS, 32'h0);
		wr(ADDR_CTRL_STATUS, 8'h80);
		@(posedge clk);
		chk("on", 32'(core_ctl.on), 32'h1);
		conv(8'hC0, 25);
	endtask
	// Only code 7 keeps the converter clock in range at 25 MHz
	task automatic t_idle();
		wr(ADDR_CTRL_STATUS, 8'h9F);
		@(posedge clk);
		cpu_idle <= 1'b1;
		wait_for(0, 1'b1);
		do @(posedge clk); while (core_ctl.tick !== 1'b1);
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (core_ctl.tick !== 1'b1);
		chk("tick spacing", 32'(i), 32'd128);
		wait_for(1, 1'b1);
		ack_pulse();
		cpu_idle <= 1'b0;
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Reset for 12 cycles, then the scenarios in order
	initial begin
		{clk, avs_read, avs_write, cpu_idle, global_irq_en, irq_vector_ack} = '0;
		{rst, clk_en} = 2'b11;
		avs_address = '0;
		avs_writedata = '0;
		{nt, err_total, n_checks} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_first();
		t_chan();
		t_lock();
		t_irq();
		t_free();
		t_abort();
		t_idle();
		close_out();
	end
	// Watchdog well beyond the few thousand cycles the scenarios need
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		close_out();
	end
endmodule
